// ### design/msd_port.sv
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
// Function
// - a 256-byte identification map answers at serial address 1010000X.
// - a diagnostics map answers at serial address 1010001X.
// - data is sampled on clock rise and stored only where unprotected.
// - driven data bits change only after a falling clock edge.
// - single-byte and sequential access through the byte pointer work.
// - the no-light flag is low normally and high with no optical input.
// - transmitter turns off within 10 us after disable is asserted.
// - diagnostics report internal calibration by default.
// - alarm and warning flags set when a value leaves its range.
// - current temperature, bias, tx power, rx power, supply are readable.
// - laser fault output is high on a fault and low otherwise.
// - transmitter is on while disable is low, off while high or open.
// - the presence pin is held at ground.
module msd_port (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  input wire logic scl_pin,
  input wire logic sda_sense,
  output logic sda_drive,
  output logic sda_oe_n,
  // status pins
  input wire logic tx_disable_pin,
  input wire logic rx_dark,
  input wire logic laser_trip,
  output logic tx_enable,
  output logic no_light_flag,
  output logic laser_fault,
  output logic presence_pin,
  // interrupt
  output logic irq
);
  localparam int NP = msd_pkg::NPARAM;
  // ==========================================================
  // synchronisers and edges
  logic [4:0] sync1_r, sync2_r;
  logic scl_d_r, sda_d_r;
  logic scl_s, sda_s, txdis_s, dark_s, trip_s;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_s = sync2_r[4];
  assign sda_s = sync2_r[3];
  assign txdis_s = sync2_r[2];
  assign dark_s = sync2_r[1];
  assign trip_s = sync2_r[0];
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= msd_pkg::SYNC_RST;
      sync2_r <= msd_pkg::SYNC_RST;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      // clock is only ever sampled, never driven
      sync1_r <= {scl_pin, sda_sense, tx_disable_pin, rx_dark, laser_trip};
      sync2_r <= sync1_r;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  // ==========================================================
  // registers
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [msd_pkg::NEV-1:0] status_r, status_nxt, mask_r, mask_nxt;
  logic [msd_pkg::NEV-1:0] ev, clr;
  logic [8:0] maddr_r, maddr_nxt;
  msd_pkg::msd_wr_s apbw_r, apbw_nxt, i2c_wr_r, i2c_wr_nxt;
  logic mpend_r, mpend_nxt;
  logic [15:0] val_r [NP], val_nxt [NP];
  msd_pkg::msd_thr_s athr_r [NP], athr_nxt [NP];
  msd_pkg::msd_thr_s wthr_r [NP], wthr_nxt [NP];
  logic [NP-1:0] ahi_r, alo_r, whi_r, wlo_r;
  logic [NP-1:0] ahi_nxt, alo_nxt, whi_nxt, wlo_nxt;
  logic [31:0] prdata_r, prdata_nxt, rd_val;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic known, commit;
  logic [11:0] pbase;
  logic nolight_r, fault_r, tx_en_r, presence_r, irq_r;
  // ==========================================================
  // serial engine state
  msd_pkg::msd_i2c_e st_r, st_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
  logic map_r, map_nxt, rw_r, rw_nxt, pdone_r, pdone_nxt;
  logic oe_n_r, oe_n_nxt, i2c_we_r, i2c_we_nxt, writable;
  logic ovr_hit_r, ovr_hit_nxt;
  logic [7:0] ovr_val_r, ovr_val_nxt, mem_rd, byte_out;
  logic mem_we;
  msd_pkg::msd_wr_s mem_wr;

  assign byte_out = ovr_hit_r ? ovr_val_r : mem_rd;
  assign mem_we = i2c_we_r || mpend_r;
  assign mem_wr = i2c_we_r ? i2c_wr_r : apbw_r;
  assign writable = map_r ? (!ctrl_r[msd_pkg::CTRL_DIAG_WP] ||
                             ptr_r >= msd_pkg::DIAG_USER_OFS)
                          : !ctrl_r[msd_pkg::CTRL_ID_WP];

  msd_mem #(.AW(msd_pkg::MAP_AW), .DW(8)) u_mem (
    .clk(pclk),
    .rstn(presetn),
    .we(mem_we),
    .waddr(mem_wr.addr),
    .wdata(mem_wr.data),
    .raddr({map_r, ptr_r}),
    .rdata_r(mem_rd)
  );
  // ==========================================================
  // serial engine
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    map_nxt = map_r;
    rw_nxt = rw_r;
    pdone_nxt = pdone_r;
    oe_n_nxt = oe_n_r;
    i2c_we_nxt = 1'b0;
    i2c_wr_nxt = i2c_wr_r;
    if (stop_c) begin
      st_nxt = msd_pkg::MSD_IDLE;
      oe_n_nxt = 1'b1;
    end else if (start_c) begin
      st_nxt = msd_pkg::MSD_DEV;
      bit_nxt = 3'h0;
      oe_n_nxt = 1'b1;
      pdone_nxt = 1'b0;
    end else begin
      unique case (st_r)
        msd_pkg::MSD_IDLE: begin
        end
        msd_pkg::MSD_DEV, msd_pkg::MSD_PTR, msd_pkg::MSD_WR: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              st_nxt = msd_pkg::MSD_ACK;
              if (st_r == msd_pkg::MSD_DEV) begin
                if (sh_r[6:0] == msd_pkg::ID_DEV_ADDR ||
                    sh_r[6:0] == msd_pkg::DIAG_DEV_ADDR) begin
                  map_nxt = sh_r[0];
                  rw_nxt = sda_s;
                end else begin
                  st_nxt = msd_pkg::MSD_IDLE;
                end
              end else if (st_r == msd_pkg::MSD_PTR) begin
                ptr_nxt = {sh_r[6:0], sda_s};
                pdone_nxt = 1'b1;
              end else begin
                i2c_we_nxt = writable;
                i2c_wr_nxt = '{addr: {map_r, ptr_r},
                               data: {sh_r[6:0], sda_s}};
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        end
        msd_pkg::MSD_ACK: begin
          if (scl_fall) begin
            if (oe_n_r) begin
              oe_n_nxt = 1'b0;
            end else if (rw_r) begin
              st_nxt = msd_pkg::MSD_RD;
              sh_nxt = byte_out;
              oe_n_nxt = byte_out[7];
              bit_nxt = 3'h0;
            end else begin
              st_nxt = pdone_r ? msd_pkg::MSD_WR : msd_pkg::MSD_PTR;
              oe_n_nxt = 1'b1;
              bit_nxt = 3'h0;
            end
          end
        end
        msd_pkg::MSD_RD: begin
          if (scl_fall) begin
            if (bit_r == 3'h7) begin
              st_nxt = msd_pkg::MSD_HACK;
              oe_n_nxt = 1'b1;
            end else begin
              bit_nxt = bit_r + 3'h1;
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_n_nxt = sh_r[6];
            end
          end
        end
        msd_pkg::MSD_HACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_nxt = msd_pkg::MSD_IDLE;
            end else begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end else if (scl_fall) begin
            st_nxt = msd_pkg::MSD_RD;
            sh_nxt = byte_out;
            oe_n_nxt = byte_out[7];
            bit_nxt = 3'h0;
          end
        end
        default: begin
          st_nxt = msd_pkg::MSD_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // live diagnostics overlay
  always_comb begin
    ovr_hit_nxt = 1'b0;
    ovr_val_nxt = 8'h00;
    if (map_r) begin
      if (ptr_r == msd_pkg::DIAG_CAL_OFS) begin
        ovr_hit_nxt = 1'b1;
        ovr_val_nxt = msd_pkg::CAL_INTERNAL;
      end
      for (int k = 0; k < NP; k++) begin
        if (ptr_r == msd_pkg::DIAG_LIVE_OFS + 8'(2 * k)) begin
          ovr_hit_nxt = 1'b1;
          ovr_val_nxt = val_r[k][15:8];
        end
        if (ptr_r == msd_pkg::DIAG_LIVE_OFS + 8'(2 * k + 1)) begin
          ovr_hit_nxt = 1'b1;
          ovr_val_nxt = val_r[k][7:0];
        end
      end
      for (int j = 0; j < 4; j++) begin
        if (ptr_r == msd_pkg::DIAG_FLAG_OFS + 8'(j)) begin
          ovr_hit_nxt = 1'b1;
          ovr_val_nxt = (j == 0) ? 8'(ahi_r) : (j == 1) ? 8'(alo_r) :
                        (j == 2) ? 8'(whi_r) : 8'(wlo_r);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= msd_pkg::MSD_IDLE;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      map_r <= 1'b0;
      rw_r <= 1'b0;
      pdone_r <= 1'b0;
      oe_n_r <= 1'b1;
      i2c_we_r <= 1'b0;
      i2c_wr_r <= '0;
      ovr_hit_r <= 1'b0;
      ovr_val_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      map_r <= map_nxt;
      rw_r <= rw_nxt;
      pdone_r <= pdone_nxt;
      oe_n_r <= oe_n_nxt;
      i2c_we_r <= i2c_we_nxt;
      i2c_wr_r <= i2c_wr_nxt;
      ovr_hit_r <= ovr_hit_nxt;
      ovr_val_r <= ovr_val_nxt;
    end
  end
  // ==========================================================
  // apb slave, flags and interrupt
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    maddr_nxt = maddr_r;
    apbw_nxt = apbw_r;
    mpend_nxt = mpend_r && i2c_we_r;
    val_nxt = val_r;
    athr_nxt = athr_r;
    wthr_nxt = wthr_r;
    pready_nxt = 1'b0;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    clr = '0;
    known = 1'b1;
    pbase = 12'h000;
    commit = psel && penable && pready_r && pwrite;
    for (int k = 0; k < NP; k++) begin
      ahi_nxt[k] = val_r[k] > athr_r[k].hi;
      alo_nxt[k] = val_r[k] < athr_r[k].lo;
      whi_nxt[k] = val_r[k] > wthr_r[k].hi;
      wlo_nxt[k] = val_r[k] < wthr_r[k].lo;
    end
    unique case (paddr)
      msd_pkg::REG_CTRL: rd_val = 32'(ctrl_r);
      msd_pkg::REG_STATUS: rd_val = 32'(status_r);
      msd_pkg::REG_MASK: rd_val = 32'(mask_r);
      msd_pkg::REG_MEM_ADDR: rd_val = 32'(maddr_r);
      msd_pkg::REG_MEM_DATA: rd_val = 32'h00000000;
      msd_pkg::REG_PINS: rd_val = 32'({st_r != msd_pkg::MSD_IDLE,
                                  txdis_s, tx_en_r, fault_r, nolight_r});
      msd_pkg::REG_FLAGS: rd_val = 32'({wlo_r, whi_r, alo_r, ahi_r});
      default: begin
        rd_val = 32'h00000000;
        known = 1'b0;
      end
    endcase
    for (int k = 0; k < NP; k++) begin
      pbase = 12'(msd_pkg::REG_PARAM_BASE + msd_pkg::REG_PARAM_STRIDE * k);
      if (paddr == pbase + msd_pkg::REG_PV_VALUE) begin
        rd_val = 32'(val_r[k]);
        known = 1'b1;
        if (commit) val_nxt[k] = pwdata[15:0];
      end
      if (paddr == pbase + msd_pkg::REG_PV_ALARM) begin
        rd_val = athr_r[k];
        known = 1'b1;
        if (commit) athr_nxt[k] = pwdata;
      end
      if (paddr == pbase + msd_pkg::REG_PV_WARN) begin
        rd_val = wthr_r[k];
        known = 1'b1;
        if (commit) wthr_nxt[k] = pwdata;
      end
    end
    if (psel && penable && !pready_r) begin
      if (!(pwrite && paddr == msd_pkg::REG_MEM_DATA && mpend_r)) begin
        pready_nxt = 1'b1;
        prdata_nxt = pwrite ? 32'h00000000 : rd_val;
        pslverr_nxt = !known;
      end
    end
    if (commit) begin
      unique case (paddr)
        msd_pkg::REG_CTRL: ctrl_nxt = pwdata[1:0];
        msd_pkg::REG_STATUS: clr = pwdata[msd_pkg::NEV-1:0];
        msd_pkg::REG_MASK: mask_nxt = pwdata[msd_pkg::NEV-1:0];
        msd_pkg::REG_MEM_ADDR: maddr_nxt = pwdata[8:0];
        msd_pkg::REG_MEM_DATA: begin
          apbw_nxt = '{addr: maddr_r, data: pwdata[7:0]};
          mpend_nxt = 1'b1;
          maddr_nxt = maddr_r + 9'h001;
        end
        default: begin
        end
      endcase
    end
    ev = '0;
    ev[msd_pkg::EV_ALARM] = |({ahi_nxt, alo_nxt} & ~{ahi_r, alo_r});
    ev[msd_pkg::EV_WARN] = |({whi_nxt, wlo_nxt} & ~{whi_r, wlo_r});
    ev[msd_pkg::EV_HOSTWR] = i2c_we_r;
    ev[msd_pkg::EV_DARK] = dark_s && !nolight_r;
    ev[msd_pkg::EV_TRIP] = trip_s && !fault_r;
    status_nxt = (status_r & ~clr) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= msd_pkg::CTRL_RST;
      status_r <= msd_pkg::STATUS_RST;
      mask_r <= msd_pkg::MASK_RST;
      maddr_r <= 9'h000;
      apbw_r <= '0;
      mpend_r <= 1'b0;
      for (int k = 0; k < NP; k++) begin
        val_r[k] <= msd_pkg::VALUE_RST;
        athr_r[k] <= '{hi: msd_pkg::THR_HI_RST, lo: msd_pkg::THR_LO_RST};
        wthr_r[k] <= '{hi: msd_pkg::THR_HI_RST, lo: msd_pkg::THR_LO_RST};
      end
      {ahi_r, alo_r, whi_r, wlo_r} <= '0;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      nolight_r <= 1'b0;
      fault_r <= 1'b0;
      tx_en_r <= 1'b0;
      presence_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      maddr_r <= maddr_nxt;
      apbw_r <= apbw_nxt;
      mpend_r <= mpend_nxt;
      val_r <= val_nxt;
      athr_r <= athr_nxt;
      wthr_r <= wthr_nxt;
      {ahi_r, alo_r, whi_r, wlo_r} <= {ahi_nxt, alo_nxt, whi_nxt, wlo_nxt};
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      nolight_r <= dark_s;
      fault_r <= trip_s;
      tx_en_r <= !txdis_s;
      presence_r <= 1'b0;
      irq_r <= |(status_r & mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sda_drive = presence_r;
  assign sda_oe_n = oe_n_r;
  assign tx_enable = tx_en_r;
  assign no_light_flag = nolight_r;
  assign laser_fault = fault_r;
  assign presence_pin = presence_r;
  assign irq = irq_r;
  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_match: assert property ((st_r == msd_pkg::MSD_DEV && scl_rise &&
    bit_r == 3'h7 && !start_c && !stop_c &&
    (sh_r[6:0] == msd_pkg::ID_DEV_ADDR ||
     sh_r[6:0] == msd_pkg::DIAG_DEV_ADDR))
    |=> st_r == msd_pkg::MSD_ACK && map_r == $past(sh_r[0]))
    else $error("own address not taken");
  a_addr_ignore: assert property ((st_r == msd_pkg::MSD_DEV && scl_rise &&
    bit_r == 3'h7 && sh_r[6:1] != msd_pkg::ID_DEV_ADDR[6:1])
    |=> st_r == msd_pkg::MSD_IDLE)
    else $error("foreign address answered");
  a_wr_on_rise: assert property (i2c_we_r
    |-> $past(scl_rise) && $past(st_r) == msd_pkg::MSD_WR)
    else $error("store not on clock rise");
  a_wr_protect: assert property (i2c_we_r |-> (i2c_wr_r.addr[8] ?
    (!$past(ctrl_r[msd_pkg::CTRL_DIAG_WP]) ||
     i2c_wr_r.addr[7:0] >= msd_pkg::DIAG_USER_OFS)
    : !$past(ctrl_r[msd_pkg::CTRL_ID_WP])))
    else $error("protected byte stored");
  a_drive_on_fall: assert property ($fell(oe_n_r) |-> $past(scl_fall))
    else $error("data driven off falling edge");
  a_ptr_advance: assert property ((st_r == msd_pkg::MSD_HACK && scl_rise &&
    !sda_s && !start_c && !stop_c)
    |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not step");
  a_los_follow: assert property ($changed(rx_dark) ##1 $stable(rx_dark)[*2]
    |=> no_light_flag == $past(rx_dark))
    else $error("no-light flag wrong");
  a_fault_follow: assert property ($rose(laser_trip) ##1 laser_trip[*2]
    |=> laser_fault)
    else $error("laser fault not shown");
  a_tx_off_time: assert property ($rose(tx_disable_pin)
    |-> ##[1:3] !tx_enable)
    else $error("transmitter not turned off");
  a_presence_low: assert property (presence_pin == 1'b0)
    else $error("presence pin not grounded");
  a_cal_byte: assert property ((map_r && ptr_r == msd_pkg::DIAG_CAL_OFS)[*3]
    |-> byte_out == msd_pkg::CAL_INTERNAL)
    else $error("calibration byte wrong");
  a_alarm_high: assert property ((val_r[0] > athr_r[0].hi)[*2]
    |-> ahi_r[0] ##1 status_r[msd_pkg::EV_ALARM] || ahi_r[0])
    else $error("high alarm not set");
  a_irq_level: assert property ((|(status_r & mask_r))[*2] |-> irq)
    else $error("interrupt missing");

  c_seq_read: cover property (st_r == msd_pkg::MSD_HACK && scl_rise && !sda_s);
  c_host_write: cover property (i2c_we_r);
  c_tx_off: cover property ($fell(tx_enable));
  c_irq: cover property ($rose(irq));
endmodule

// ### design/msd_pkg.sv
package msd_pkg;
  // ==========================================================
  // serial addresses and map layout
  localparam logic [6:0] ID_DEV_ADDR = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  localparam int MAP_AW = 9;
  localparam int NPARAM = 5;
  localparam logic [7:0] DIAG_USER_OFS = 8'h80;
  localparam logic [7:0] DIAG_CAL_OFS = 8'h5C;
  localparam logic [7:0] CAL_INTERNAL = 8'h20;
  localparam logic [7:0] DIAG_LIVE_OFS = 8'h60;
  localparam logic [7:0] DIAG_FLAG_OFS = 8'h70;
  // ==========================================================
  // apb register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MASK = 12'h008;
  localparam logic [11:0] REG_MEM_ADDR = 12'h00C;
  localparam logic [11:0] REG_MEM_DATA = 12'h010;
  localparam logic [11:0] REG_PINS = 12'h014;
  localparam logic [11:0] REG_FLAGS = 12'h018;
  localparam logic [11:0] REG_PARAM_BASE = 12'h040;
  localparam logic [11:0] REG_PARAM_STRIDE = 12'h010;
  localparam logic [11:0] REG_PV_VALUE = 12'h000;
  localparam logic [11:0] REG_PV_ALARM = 12'h004;
  localparam logic [11:0] REG_PV_WARN = 12'h008;
  // ==========================================================
  // fields and reset values
  localparam int CTRL_ID_WP = 0;
  localparam int CTRL_DIAG_WP = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int NEV = 5;
  localparam int EV_ALARM = 0;
  localparam int EV_WARN = 1;
  localparam int EV_HOSTWR = 2;
  localparam int EV_DARK = 3;
  localparam int EV_TRIP = 4;
  localparam logic [NEV-1:0] STATUS_RST = 5'h00;
  localparam logic [NEV-1:0] MASK_RST = 5'h00;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [15:0] THR_HI_RST = 16'hFFFF;
  localparam logic [15:0] THR_LO_RST = 16'h0000;
  localparam logic [4:0] SYNC_RST = 5'h1C;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TXDIS_TIME_NS = 10000;
  localparam int TXDIS_CYC = TXDIS_TIME_NS / CLK_PERIOD_NS;
  // ==========================================================
  // types
  typedef struct packed {
    logic [MAP_AW-1:0] addr;
    logic [7:0] data;
  } msd_wr_s;
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } msd_thr_s;
  typedef enum logic [2:0] {
    MSD_IDLE, MSD_DEV, MSD_PTR, MSD_WR, MSD_ACK, MSD_RD, MSD_HACK
  } msd_i2c_e;
endpackage

// ### design/msd_mem.sv
`timescale 1ns/10ps
module msd_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
endmodule

// ### testbench/msd_host.sv
`timescale 1ns/10ps
// ==========
// host side of the two-wire link
module msd_host (
  // link
  output logic scl,
  output logic sda_oe_n,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  // start or repeated start, scl left low
  task automatic start();
    #4 sda_oe_n = 1'b1;
    #12 scl = 1'b1;
    #8 sda_oe_n = 1'b0;
    #8 scl = 1'b0;
  endtask
  // stop, scl stands high after it
  task automatic stop();
    #4 sda_oe_n = 1'b0;
    #12 scl = 1'b1;
    #8 sda_oe_n = 1'b1;
  endtask
  // eight bits msb first, then the ack slot
  task automatic xbyte(input logic [7:0] d, input logic rd, input logic ak,
                       output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      #4 sda_oe_n = rd | d[i];
      #12 scl = 1'b1;
      q[i] = sda;
      #16 scl = 1'b0;
    end
    #4 sda_oe_n = rd ? ak : 1'b1;
    #12 scl = 1'b1;
    a = sda;
    #16 scl = 1'b0;
  endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/10ps
// ==========
// bench top
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, scl, h_oe_n, irq, re;
  logic pready, pslverr, sda_oe_n, tx_disable_pin, rx_dark, laser_trip;
  logic tx_enable, no_light_flag, laser_fault, presence_pin, sda_drive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [7:0] bf [2];
  logic [7:0] p, d0;
  logic [15:0] v;
  int failures, n_tests;
  wire logic sda_w = h_oe_n & sda_oe_n;
  always #2 pclk = ~pclk;
  msd_port i_msd_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_pin(scl),
    .sda_sense(sda_w), .sda_drive(sda_drive), .sda_oe_n(sda_oe_n),
    .tx_disable_pin(tx_disable_pin), .rx_dark(rx_dark),
    .laser_trip(laser_trip), .tx_enable(tx_enable),
    .no_light_flag(no_light_flag), .laser_fault(laser_fault),
    .presence_pin(presence_pin), .irq(irq));
  msd_host i_msd_host (.scl(scl), .sda_oe_n(h_oe_n), .sda(sda_w));
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one apb transfer, result in rq and re
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // serial write or random read of n bytes through bf
  task automatic sacc(input logic [7:0] dv, pt, input int n,
                      input logic rd);
    logic [7:0] q;
    logic a;
    @(negedge pclk);
    i_msd_host.start();
    i_msd_host.xbyte(dv, 1'b0, 1'b1, q, a);
    chk("dev ack", 0, a);
    i_msd_host.xbyte(pt, 1'b0, 1'b1, q, a);
    if (rd) begin
      i_msd_host.start();
      i_msd_host.xbyte(dv | 8'h01, 1'b0, 1'b1, q, a);
    end
    for (int i = 0; i < n; i++) begin
      i_msd_host.xbyte(bf[i], rd, 1'(i == n - 1), q, a);
      if (rd) bf[i] = q;
      else chk("data ack", 0, a);
    end
    i_msd_host.stop();
  endtask
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, rx_dark, laser_trip} = '0;
    {paddr, pwdata} = '0;
    tx_disable_pin = 1'b1;
    void'($urandom(42));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("presence", 0, presence_pin);
    chk("sda drive", 0, sda_drive);
    chk("tx open", 0, tx_enable);
    apb(1'b0, msd_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", 32'(msd_pkg::CTRL_RST), rq);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", 1, re);
    for (int i = 0; i < 8; i++) begin
      rx_dark <= 1'($urandom);
      laser_trip <= 1'($urandom);
      tx_disable_pin <= 1'($urandom);
      repeat (8) @(posedge pclk);
      chk("no light", rx_dark, no_light_flag);
      chk("fault", laser_trip, laser_fault);
      chk("tx enable", !tx_disable_pin, tx_enable);
    end
    {rx_dark, laser_trip} <= 2'h0;
    apb(1'b1, msd_pkg::REG_STATUS, 32'h1F);
    {rx_dark, laser_trip} <= 2'h3;
    apb(1'b1, msd_pkg::REG_MASK, 32'h1F);
    apb(1'b0, msd_pkg::REG_STATUS, 32'h0);
    chk("pin events", 32'h18, rq);
    {rx_dark, laser_trip} <= 2'h0;
    apb(1'b1, msd_pkg::REG_STATUS, 32'h1F);
    repeat (2) @(posedge pclk);
    chk("irq clear", 0, irq);
    for (int k = 0; k < msd_pkg::NPARAM; k++) begin
      v = 16'($urandom_range(16'hFFF0, 16'h0100));
      p = 8'(12'(msd_pkg::REG_PARAM_BASE + msd_pkg::REG_PARAM_STRIDE * k));
      apb(1'b1, 12'(p) + msd_pkg::REG_PV_ALARM, {v - 16'h0001, 16'h0000});
      apb(1'b1, 12'(p) + msd_pkg::REG_PV_VALUE, 32'(v));
      apb(1'b0, msd_pkg::REG_FLAGS, 32'h0);
      chk("alarm flags", 32'((2 ** (k + 1)) - 1), rq);
      sacc(8'hA2, msd_pkg::DIAG_LIVE_OFS + 8'(2 * k), 2, 1'b1);
      chk("live value", 32'(v), 32'({bf[0], bf[1]}));
    end
    apb(1'b0, msd_pkg::REG_STATUS, 32'h0);
    chk("alarm event", 1, rq[msd_pkg::EV_ALARM]);
    chk("irq set", 1, irq);
    apb(1'b1, msd_pkg::REG_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 0, irq);
    apb(1'b1, msd_pkg::REG_STATUS, 32'h1F);
    apb(1'b0, msd_pkg::REG_STATUS, 32'h0);
    chk("status clear", 0, rq);
    apb(1'b1, msd_pkg::REG_CTRL, 32'h0);
    p = 8'($urandom);
    bf[0] = 8'($urandom);
    bf[1] = 8'($urandom);
    d0 = bf[0];
    v = {bf[0], bf[1]};
    sacc(8'hA0, p, 2, 1'b0);
    sacc(8'hA0, p, 2, 1'b1);
    chk("id bytes", 32'(v), 32'({bf[0], bf[1]}));
    apb(1'b0, msd_pkg::REG_STATUS, 32'h0);
    chk("stored event", 1, rq[msd_pkg::EV_HOSTWR]);
    apb(1'b1, msd_pkg::REG_CTRL, 32'h1);
    bf[0] = ~d0;
    sacc(8'hA0, p, 1, 1'b0);
    sacc(8'hA0, p, 1, 1'b1);
    chk("protected", 32'(d0), 32'(bf[0]));
    sacc(8'hA2, msd_pkg::DIAG_CAL_OFS, 1, 1'b1);
    chk("cal mode", 32'(msd_pkg::CAL_INTERNAL), 32'(bf[0]));
    @(negedge pclk);
    i_msd_host.start();
    i_msd_host.xbyte(8'hA4, 1'b0, 1'b1, p, re);
    chk("foreign nack", 1, re);
    i_msd_host.stop();
    tally_and_finish();
  end
endmodule
